// File: cac_grabber.sv
/*
 Four camera acquisition channels: pin sampling, trigger sequencing,
 strobe, window, decimation, field merge, slot selection, lookup table,
 camera timebase and a two-entry write buffer per channel.
 Assumes camera pins are asynchronous to clk_sys and the frame buffer
 accepts words with valid/ready.
*/
//
// Behaviour
// R1 - Four independent channels, each own camera timing
// R2 - Trigger on falling edge, pulse at least 50ns
// R3 - Frame reset mode: reset, strobe, then capture
// R4 - Trigger on frame: aligned to incoming video
// R5 - Strobe polarity selectable, lasts 120 ms
// R6 - Strobe position programmable in line, pixel
// R7 - Reset to capture delay 1 to 511 lines
// R8 - Capture may start at next field boundary
// R9 - Window horizontal start pixel 0 to 1023
// R10 - Window width 4 to 1024, multiples four
// R11 - Window vertical start line 0 to 1023
// R12 - Window height 1 to 1024 lines
// R13 - Events: strobe, trigger, vertical blank, acquired
// R14 - Decimation halves both directions when enabled
// R15 - De-interlace merges fields into one frame
// R16 - Multi-frame mode stores up to eight images
// R17 - Ping-pong alternates two areas per frame
// R18 - Every pixel passes 8-bit lookup table
// R19 - Timebase drives camera syncs, interlaced or progressive
// R20 - Pixel rates up to 20 MHz accepted
// R21 - Trigger during a running sequence is ignored
`timescale 1ns/1ps
module cac_channel
	import cac_pkg::*;
#(
	parameter int STROBE_CYCLES = STROBE_CYC
)(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Configuration and control
	input  wire cac_cfg_t     cfg,
	input  wire logic         acq_req,
	input  wire logic         lut_we,
	input  wire logic [7:0]   lut_addr,
	input  wire logic [7:0]   lut_data,
	// Camera
	input  wire cac_cam_in_t  cam_in,
	output cac_cam_out_t      cam_out,
	// Frame buffer writes
	output cac_wr_t           wr,
	output logic              wr_valid,
	input  wire logic         wr_ready,
	// Status
	output cac_evt_t          evt,
	output logic              busy,
	output logic              overrun
);
	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic [3:0]  s1_r, s2_r, s3_r, lvl_r, lvl_q_r, lvl_nxt, rise, fall;
	logic [7:0]  d1_r, d2_r, d3_r;
	always_ff @(posedge clk_sys)
	begin
		s1_r    <= {cam_in.trigger_n, cam_in.frame_sync_in, cam_in.line_sync_in, cam_in.pclk};
		s2_r    <= s1_r;
		s3_r    <= s2_r;
		d1_r    <= cam_in.pixel;
		d2_r    <= d1_r;
		d3_r    <= d2_r;
		lvl_r   <= srst ? 4'hF : lvl_nxt;
		lvl_q_r <= srst ? 4'hF : lvl_r;
	end
	// Level moves only where stages two and three agree [R2]
	assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
	assign rise    = lvl_r & ~lvl_q_r;
	assign fall    = ~lvl_r & lvl_q_r;
	wire pclk_rise = rise[0];
	wire line_edge = fall[1];
	wire frame_edge = fall[2];
	wire trig_fall = fall[3];                                             // [R2]

	// ----------------------------------------
	// Video position counters
	// ----------------------------------------
	cac_state_t  st_r, st_nxt;
	logic [10:0] pix_cnt_r, line_cnt_r;
	logic        field_r, bank_r, strobe_done_r, half_r, ovf_r;
	logic [2:0]  frame_idx_r;
	logic [8:0]  dly_cnt_r;
	wire         dly_done = line_edge && (dly_cnt_r + 9'h001 >= cfg.reset_dly);  // [R7]
	always_ff @(posedge clk_sys)
	begin
		if (srst || line_edge)
			pix_cnt_r <= 11'h000;
		else if (pclk_rise && pix_cnt_r != 11'h7FF)
			pix_cnt_r <= pix_cnt_r + 11'h001;
		if (srst || frame_edge || (st_r == ST_RESET) || (st_r == ST_DELAY && dly_done))
			line_cnt_r <= 11'h000;
		else if (line_edge && line_cnt_r != 11'h7FF)
			line_cnt_r <= line_cnt_r + 11'h001;
		if (srst)
			field_r <= 1'b0;
		else if (frame_edge)
			field_r <= ~field_r;
	end

	// ----------------------------------------
	// Trigger and capture sequence
	// ----------------------------------------
	wire [10:0] v_end     = {1'b0, cfg.v_start} + {1'b0, cfg.v_size_m1} + 11'h001;  // [R11] [R12]
	wire        capt_end  = (line_edge && line_cnt_r >= v_end) || frame_edge;
	wire        more_fld  = cfg.deint && !half_r;                                 // [R15]
	wire        more_frm  = frame_idx_r != cfg.multi_m1;                          // [R16]
	wire        frm_done  = st_r == ST_CAPT && capt_end && !more_fld;
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
				if (trig_fall && cfg.trig_en && cfg.trig_mode == MODE_FRST)
					st_nxt = ST_RESET;                                       // [R3]
				else if (trig_fall && cfg.trig_en && cfg.trig_mode == MODE_TOF)
					st_nxt = ST_WAIT;                                        // [R4]
				else if (acq_req)
					st_nxt = ST_WAIT;                                        // [R8]
			ST_RESET:
				if (line_edge)
					st_nxt = ST_DELAY;
			ST_DELAY:
				if (dly_done)
					st_nxt = ST_CAPT;                                        // [R7]
			ST_WAIT:
				if (frame_edge)
					st_nxt = ST_CAPT;
			ST_CAPT:
				if (capt_end)
					st_nxt = (more_fld || (more_frm && !cfg.pingpong)) ? ST_WAIT : ST_IDLE;
			default:
				st_nxt = ST_IDLE;
		endcase
	end
	// Triggers outside ST_IDLE fall through the case above [R21]
	always_ff @(posedge clk_sys)
	begin
		st_r <= srst ? ST_IDLE : st_nxt;
		if (srst || st_r != ST_DELAY)
			dly_cnt_r <= 9'h000;
		else if (line_edge)
			dly_cnt_r <= dly_cnt_r + 9'h001;
		if (srst || st_r == ST_IDLE)
			half_r <= 1'b0;
		else if (st_r == ST_CAPT && capt_end)
			half_r <= ~half_r;
		if (srst || (st_r == ST_IDLE && st_nxt != ST_IDLE))
			frame_idx_r <= 3'h0;
		else if (frm_done && !cfg.pingpong)
			frame_idx_r <= frame_idx_r + 3'h1;                           // [R16]
		if (srst)
			bank_r <= 1'b0;
		else if (frm_done && cfg.pingpong)
			bank_r <= ~bank_r;                                           // [R17]
	end

	// ----------------------------------------
	// Strobe
	// ----------------------------------------
	logic [23:0] str_cnt_r;
	logic        strobe_on_r;
	wire         str_fire = st_r != ST_IDLE && !strobe_done_r && !strobe_on_r
	                        && line_cnt_r == {1'b0, cfg.strobe_line}
	                        && pix_cnt_r == {1'b0, cfg.strobe_pix};          // [R6]
	always_ff @(posedge clk_sys)
	begin
		if (srst || str_fire)
			str_cnt_r <= 24'h000000;
		else if (strobe_on_r)
			str_cnt_r <= str_cnt_r + 24'h000001;
		if (srst || (strobe_on_r && str_cnt_r == 24'(STROBE_CYCLES - 1)))
			strobe_on_r <= 1'b0;                                         // [R5]
		else if (str_fire)
			strobe_on_r <= 1'b1;
		if (srst || st_r == ST_IDLE)
			strobe_done_r <= 1'b0;
		else if (str_fire)
			strobe_done_r <= 1'b1;
	end

	// ----------------------------------------
	// Window, decimation, address, lookup
	// ----------------------------------------
	logic [7:0] lut_r [256];
	always_ff @(posedge clk_sys)
		if (lut_we)
			lut_r[lut_addr] <= lut_data;
	wire [10:0] h_end  = {1'b0, cfg.h_start} + {1'b0, cfg.w_quads_m1, 2'b00} + 11'h004;  // [R10]
	wire        in_h   = pix_cnt_r >= {1'b0, cfg.h_start} && pix_cnt_r < h_end;          // [R9]
	wire        in_v   = line_cnt_r >= {1'b0, cfg.v_start} && line_cnt_r < v_end;
	wire [9:0]  x      = 10'(pix_cnt_r - {1'b0, cfg.h_start});
	wire [9:0]  y      = 10'(line_cnt_r - {1'b0, cfg.v_start});
	wire        keep   = !cfg.decim || (!x[0] && !y[0]);                 // [R14]
	wire [9:0]  x_o    = cfg.decim ? {1'b0, x[9:1]} : x;
	wire [9:0]  y_d    = cfg.decim ? {1'b0, y[9:1]} : y;
	wire [9:0]  y_o    = cfg.deint ? {y_d[8:0], half_r} : y_d;           // [R15]
	wire [2:0]  slot   = cfg.pingpong ? {2'h0, bank_r} : frame_idx_r;    // [R16] [R17]
	wire        take   = st_r == ST_CAPT && pclk_rise && in_h && in_v && keep;
	cac_wr_t    in_w;
	assign in_w.addr = {slot, y_o, x_o};
	assign in_w.data = lut_r[d3_r];                                      // [R18]

	// ----------------------------------------
	// Two-entry write buffer
	// ----------------------------------------
	cac_wr_t    buf_r [2];
	logic       wptr_r, rptr_r;
	logic [1:0] cnt_r;
	wire        in_ready = cnt_r != 2'h2;
	wire        push     = take && in_ready;                             // [R20]
	wire        pop      = wr_valid && wr_ready;
	always_ff @(posedge clk_sys)
	begin
		if (push)
			buf_r[wptr_r] <= in_w;
		wptr_r <= srst ? 1'b0 : wptr_r ^ push;
		rptr_r <= srst ? 1'b0 : rptr_r ^ pop;
		cnt_r  <= srst ? 2'h0 : 2'(cnt_r + {1'b0, push} - {1'b0, pop});
		// Camera cannot be stalled, so a full buffer flags the lost pixel
		ovf_r  <= srst ? 1'b0 : (ovf_r || (take && !in_ready));
	end
	assign wr       = buf_r[rptr_r];
	assign wr_valid = cnt_r != 2'h0;
	assign overrun  = ovf_r;

	// ----------------------------------------
	// Camera timebase
	// ----------------------------------------
	logic [3:0]  div_r;
	logic [10:0] tb_h_r, tb_v_r;
	logic        tb_fld_r, frst_r, evt_r_acq;
	wire         tb_tick = div_r == cfg.tb_div;
	wire [10:0]  v_last  = cfg.tb_v_total + {10'h000, cfg.tb_interlace & tb_fld_r};  // [R19]
	always_ff @(posedge clk_sys)
	begin
		div_r <= (srst || tb_tick) ? 4'h0 : div_r + 4'h1;
		if (srst || (tb_tick && tb_h_r == cfg.tb_h_total))
			tb_h_r <= 11'h000;
		else if (tb_tick)
			tb_h_r <= tb_h_r + 11'h001;
		if (srst || (tb_tick && tb_h_r == cfg.tb_h_total && tb_v_r == v_last))
			tb_v_r <= 11'h000;
		else if (tb_tick && tb_h_r == cfg.tb_h_total)
			tb_v_r <= tb_v_r + 11'h001;
		if (srst)
			tb_fld_r <= 1'b0;
		else if (tb_tick && tb_h_r == cfg.tb_h_total && tb_v_r == v_last)
			tb_fld_r <= cfg.tb_interlace & ~tb_fld_r;
		cam_out.line_sync_out  <= srst ? 1'b1 : !(tb_h_r < {3'h0, cfg.tb_hs_len});
		cam_out.frame_sync_out <= srst ? 1'b1 : !(tb_v_r < {7'h00, cfg.tb_vs_len});
		frst_r                 <= srst ? 1'b0 : st_nxt == ST_RESET;  // [R3]
		cam_out.strobe_out     <= srst ? cfg.strobe_pol : strobe_on_r ^ cfg.strobe_pol;  // [R5]
		evt.strobe             <= srst ? 1'b0 : str_fire;                // [R13]
		evt.trigger            <= srst ? 1'b0 : trig_fall && cfg.trig_en;
		evt.vertical_blank_event <= srst ? 1'b0 : frame_edge;
		evt_r_acq              <= srst ? 1'b0 : frm_done;
	end
	assign cam_out.camera_frame_reset_out = frst_r;
	assign evt.acquired = evt_r_acq;
	assign busy         = st_r != ST_IDLE;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_trig_idle;
		st_r == ST_IDLE && trig_fall && cfg.trig_en;
	endsequence
	sequence s_reset_seen;
		st_r == ST_RESET ##0 cam_out.camera_frame_reset_out;
	endsequence
	chk_frame_reset_start: assert property (s_trig_idle ##0 cfg.trig_mode == MODE_FRST |=> s_reset_seen) // [R3]
		else $error("frame reset not started by trigger");
	chk_tof_wait_video: assert property (s_trig_idle ##0 cfg.trig_mode == MODE_TOF |=> st_r == ST_WAIT && !frst_r) // [R4]
		else $error("trigger on frame did not wait for video");
	chk_trig_ignored: assert property (st_r == ST_WAIT && trig_fall && !frame_edge |=> st_r == ST_WAIT) // [R21]
		else $error("trigger disturbed running sequence");
	chk_strobe_length: assert property ($fell(strobe_on_r) |-> $past(str_cnt_r) == 24'(STROBE_CYCLES - 1)) // [R5]
		else $error("strobe length wrong");
	chk_delay_lines: assert property (st_r == ST_DELAY && st_nxt == ST_CAPT |-> dly_cnt_r + 9'h001 >= cfg.reset_dly) // [R7]
		else $error("capture began before reset delay");
	chk_window_bounds: assert property (push |-> pix_cnt_r < h_end && line_cnt_r < v_end && pix_cnt_r >= {1'b0, cfg.h_start}) // [R9]
		else $error("pixel stored outside window");
	chk_decim_even: assert property (push && cfg.decim |-> !x[0] && !y[0]) // [R14]
		else $error("decimation kept odd pixel");
	chk_lut_path: assert property (push && cnt_r == 2'h0 |=> wr_valid && wr.data == lut_r[$past(d3_r)]) // [R18]
		else $error("stored pixel bypassed lookup");
	chk_buf_hold: assert property (cnt_r == 2'h2 && !wr_ready |=> cnt_r == 2'h2 ##0 wr_valid) // [R20]
		else $error("full buffer lost a word");
	chk_trig_event: assert property (s_trig_idle |=> evt.trigger) // [R13]
		else $error("trigger event missing");
endmodule : cac_channel

`timescale 1ns/1ps
module cac_grabber
	import cac_pkg::*;
#(
	parameter int N_CH          = NUM_CH,
	parameter int STROBE_CYCLES = STROBE_CYC
)(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Configuration and control per channel, lookup address and data shared
	input  wire cac_cfg_t     cfg      [N_CH],
	input  wire logic         acq_req  [N_CH],
	input  wire logic         lut_we   [N_CH],
	input  wire logic [7:0]   lut_addr,
	input  wire logic [7:0]   lut_data,
	// Cameras
	input  wire cac_cam_in_t  cam_in   [N_CH],
	output cac_cam_out_t      cam_out  [N_CH],
	// Frame buffer writes
	output cac_wr_t           wr       [N_CH],
	output logic              wr_valid [N_CH],
	input  wire logic         wr_ready [N_CH],
	// Status
	output cac_evt_t          evt      [N_CH],
	output logic              busy     [N_CH],
	output logic              overrun  [N_CH]
);
	// Sampling needs at least four clocks per pixel clock period
	if (N_CH < 1 || STROBE_CYCLES < 2 || CLK_MHZ < 4 * PIX_MHZ_MAX)
		$error("cac_grabber: unsupported parameters");
	for (genvar i = 0; i < N_CH; i++)
	begin : g_ch
		cac_channel #(.STROBE_CYCLES(STROBE_CYCLES)) u_ch (             // [R1]
			.clk_sys  (clk_sys),
			.srst     (srst),
			.cfg      (cfg[i]),
			.acq_req  (acq_req[i]),
			.lut_we   (lut_we[i]),
			.lut_addr (lut_addr),
			.lut_data (lut_data),
			.cam_in   (cam_in[i]),
			.cam_out  (cam_out[i]),
			.wr       (wr[i]),
			.wr_valid (wr_valid[i]),
			.wr_ready (wr_ready[i]),
			.evt      (evt[i]),
			.busy     (busy[i]),
			.overrun  (overrun[i])
		);
	end
endmodule : cac_grabber

// File: cac_pkg.sv
/*
 Package for the camera acquisition channel: configuration and port
 structs, sequence states and timing constants.
 Assumes a 100 MHz system clock that samples every camera pin.
*/
package cac_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int PIX_MHZ_MAX    = 20;
	localparam int TRIG_MIN_NS    = 50;
	localparam int TRIG_MIN_CYC   = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_MS      = 120;
	localparam int STROBE_CYC     = STROBE_MS * CLK_MHZ * 1000;
	localparam int NUM_CH         = 4;
	// ----------------------------------------
	// Field widths and reset values
	// ----------------------------------------
	localparam int ADDR_W         = 23;
	localparam int SLOT_POS       = 20;
	localparam int LINE_POS       = 10;
	localparam int TB_DIV_RST     = 5;
	localparam int MODE_W         = 2;
	localparam logic [MODE_W-1:0] MODE_FREE  = 2'h0;
	localparam logic [MODE_W-1:0] MODE_FRST  = 2'h1;
	localparam logic [MODE_W-1:0] MODE_TOF   = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_RESET, ST_DELAY, ST_WAIT, ST_CAPT} cac_state_t;

	typedef struct packed {
		logic [1:0]  trig_mode;
		logic        trig_en;
		logic        strobe_pol;
		logic [9:0]  strobe_line;
		logic [9:0]  strobe_pix;
		logic [8:0]  reset_dly;
		logic [9:0]  h_start;
		logic [7:0]  w_quads_m1;
		logic [9:0]  v_start;
		logic [9:0]  v_size_m1;
		logic        decim;
		logic        deint;
		logic [2:0]  multi_m1;
		logic        pingpong;
		logic        tb_interlace;
		logic [10:0] tb_h_total;
		logic [10:0] tb_v_total;
		logic [7:0]  tb_hs_len;
		logic [3:0]  tb_vs_len;
		logic [3:0]  tb_div;
	} cac_cfg_t;

	typedef struct packed {
		logic       pclk;
		logic       line_sync_in;
		logic       frame_sync_in;
		logic       trigger_n;
		logic [7:0] pixel;
	} cac_cam_in_t;

	typedef struct packed {
		logic line_sync_out;
		logic frame_sync_out;
		logic camera_frame_reset_out;
		logic strobe_out;
	} cac_cam_out_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} cac_wr_t;

	typedef struct packed {
		logic strobe;
		logic trigger;
		logic vertical_blank_event;
		logic acquired;
	} cac_evt_t;
endpackage : cac_pkg

// File: cac_cam_model.sv
/*
 Behavioural area scan camera for one channel: pixel clock, line and
 frame syncs, a constant pixel value and a trigger pulse on request.
 Assumes the 100 MHz system clock; restarts its frame on frame reset.
*/
`timescale 1ns/1ps
module cac_cam_model
	import cac_pkg::*;
#(
	parameter int H_TOT = 32,
	parameter int V_TOT = 12
)(
	// Clock
	input  wire logic       clk_sys,
	// Control from bench and channel
	input  wire logic       trig_go,
	input  wire logic       frame_reset,
	input  wire logic [7:0] pix_val,
	// Camera pins
	output cac_cam_in_t     cam
);
	// ----------------------------------------
	// Line and frame timing
	// ----------------------------------------
	logic [2:0] ph_r   = 3'h0;
	logic [5:0] px_r   = 6'h00;
	logic [4:0] ln_r   = 5'h00;
	logic [2:0] trig_r = 3'h0;

	always_ff @(posedge clk_sys)
	begin
		ph_r <= ph_r + 3'h1;
		if (ph_r == 3'h7)
		begin
			px_r <= (px_r == 6'(H_TOT - 1)) ? 6'h00 : px_r + 6'h01;
			// Frame restarts at the line edge that ends the reset
			if (px_r == 6'(H_TOT - 1))
				ln_r <= (frame_reset || ln_r == 5'(V_TOT - 1)) ? 5'h00 : ln_r + 5'h01;
		end
		// Six clocks low, just over the shortest legal pulse
		trig_r <= trig_go ? 3'h6 : (trig_r != 3'h0) ? trig_r - 3'h1 : 3'h0;
	end

	// Four clocks a phase: a 12.5 MHz pixel clock, below the 20 MHz limit
	assign cam.pclk          = ph_r[2];
	assign cam.line_sync_in  = (px_r > 6'h01);
	assign cam.frame_sync_in = (ln_r > 5'h01);
	assign cam.trigger_n     = (trig_r == 3'h0);
	assign cam.pixel         = pix_val;
endmodule : cac_cam_model

// File: test_cac_grabber.sv
/*
 Bench for the four-channel grabber: table of capture cases, then
 buffer overrun and a second reset by hand.
 Assumes cac_cam_model on every camera input and a short strobe.
*/
`timescale 1ns/1ps
module test_cac_grabber
	import cac_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int STB = 20;
	typedef struct packed {
		logic [1:0] ch;
		logic [1:0] mode;
		logic       decim;
		logic [9:0] hs;
		logic [7:0] wq;
		logic [9:0] vs;
		logic [9:0] vsm;
		logic [1:0] stall;
		logic [7:0] pix;
	} cac_row_t;
	logic              clk_sys = 1'b0;
	logic              srst    = 1'b1;
	cac_cfg_t          cfg      [4];
	logic              acq_req  [4];
	logic              lut_we   [4];
	logic [7:0]        lut_addr = 8'h00;
	logic [7:0]        lut_data = 8'h00;
	wire cac_cam_in_t  cam_in   [4];
	wire cac_cam_out_t cam_out  [4];
	wire cac_wr_t      wr       [4];
	wire logic         wr_valid [4];
	logic              wr_ready [4];
	wire cac_evt_t     evt      [4];
	wire logic         busy     [4];
	wire logic         overrun  [4];
	logic              trig_go  [4];
	logic [7:0]        pix      [4];
	logic              fr_q, ls_q;
	int                failures, n_compared, cyc, nw, nfr, slen, slast, lper, lcnt, ew, eh;
	int                n_ev     [4];
	cac_row_t          cur = '0;
	cac_row_t          rows [5] = '{
		'{2'h0, MODE_FREE, 1'b0, 10'h004, 8'h01, 10'h002, 10'h002, 2'h1, 8'h3C},
		'{2'h1, MODE_FREE, 1'b1, 10'h000, 8'h03, 10'h000, 10'h003, 2'h3, 8'h81},
		'{2'h2, MODE_FRST, 1'b0, 10'h004, 8'h00, 10'h001, 10'h000, 2'h2, 8'h00},
		'{2'h3, MODE_TOF,  1'b0, 10'h008, 8'h01, 10'h003, 10'h001, 2'h1, 8'hFF},
		'{2'h1, MODE_FREE, 1'b0, 10'h004, 8'h01, 10'h002, 10'h002, 2'h0, 8'h77}};

	cac_grabber #(.N_CH(4), .STROBE_CYCLES(STB)) dut (
		.clk_sys(clk_sys), .srst(srst), .cfg(cfg), .acq_req(acq_req), .lut_we(lut_we),
		.lut_addr(lut_addr), .lut_data(lut_data), .cam_in(cam_in), .cam_out(cam_out),
		.wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready), .evt(evt), .busy(busy),
		.overrun(overrun));

	for (genvar g = 0; g < 4; g++)
	begin : g_cam
		cac_cam_model cam_i (.clk_sys(clk_sys), .trig_go(trig_go[g]), .pix_val(pix[g]),
			.frame_reset(cam_out[g].camera_frame_reset_out), .cam(cam_in[g]));
	end

	always #5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Checks and monitors
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : check

	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	always @(posedge clk_sys)
	begin
		int c;
		c = cur.ch;
		cyc++;
		for (int i = 0; i < 4; i++)
		begin
			// Sink stalls on a pattern still faster than the pixel rate; stall 0 holds ready low
			wr_ready[i] <= (cur.stall != 2'h0) && (cyc % int'(cur.stall) == 0);
			if (wr_valid[i] === 1'b1 && wr_ready[i] === 1'b1)
			begin
				nw++;
				check(i, c);
				check(wr[i].data, cur.pix ^ 8'hA5);
				check(wr[i].addr[9:0] < ew, 1);
				check(wr[i].addr[19:10] < eh, 1);
				check(wr[i].addr[22:20], 0);
			end
			n_ev[i] += (evt[c][i] === 1'b1);
		end
		nfr += (cam_out[c].camera_frame_reset_out === 1'b1 && fr_q !== 1'b1);
		fr_q = cam_out[c].camera_frame_reset_out;
		if (cam_out[c].strobe_out !== cfg[c].strobe_pol)
			slen++;
		else if (slen != 0)
		begin
			slast = slen;
			slen = 0;
		end
		lcnt++;
		if (cam_out[0].line_sync_out === 1'b0 && ls_q === 1'b1)
		begin
			lper = lcnt;
			lcnt = 0;
		end
		ls_q = cam_out[0].line_sync_out;
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic run_row(input cac_row_t r);
		int k;
		@(posedge clk_sys);
		cur <= r;
		ew = ((int'(r.wq) + 1) * 4) >> r.decim;
		eh = (int'(r.vsm) + 1 + int'(r.decim)) >> r.decim;
		nw = 0;
		nfr = 0;
		slast = 0;
		n_ev = '{default: 0};
		cfg[r.ch].trig_mode <= r.mode;
		cfg[r.ch].trig_en <= (r.mode != MODE_FREE);
		cfg[r.ch].strobe_pol <= (r.mode == MODE_TOF);
		cfg[r.ch].h_start <= r.hs;
		cfg[r.ch].w_quads_m1 <= r.wq;
		cfg[r.ch].v_start <= r.vs;
		cfg[r.ch].v_size_m1 <= r.vsm;
		cfg[r.ch].decim <= r.decim;
		pix[r.ch] <= r.pix;
		repeat (4) @(posedge clk_sys);
		acq_req[r.ch] <= (r.mode == MODE_FREE);
		trig_go[r.ch] <= (r.mode != MODE_FREE);
		@(posedge clk_sys);
		acq_req[r.ch] <= 1'b0;
		trig_go[r.ch] <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1 check(busy[r.ch], 1'b1);
		@(posedge clk_sys);
		// In trigger modes a second trigger lands while the sequence still runs
		trig_go[r.ch] <= (r.mode != MODE_FREE);
		@(posedge clk_sys);
		trig_go[r.ch] <= 1'b0;
		for (k = 0; k < 20000 && n_ev[0] == 0; k++)
			@(posedge clk_sys);
		repeat (300) @(posedge clk_sys);
		#1 check(k < 20000, 1);
		check(nw, (r.stall != 2'h0) ? ew * eh : 0);
		check(n_ev[0], 1);
		if (r.mode != MODE_FREE)
		begin
			check(n_ev[2], 2);
			check(n_ev[3], 1);
			check(slast, STB);
			check(nfr, (r.mode == MODE_FRST));
		end
		@(posedge clk_sys);
		cfg[r.ch].trig_en <= 1'b0;
		$display("case ch%0d mode %0d done, %0d words", r.ch, r.mode, nw);
	endtask : run_row

	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			cfg[i] = '{2'h0, 1'b0, 1'b0, 10'h001, 10'h003, 9'h002, 10'h000, 8'h00, 10'h000,
				10'h000, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 11'h03F, 11'h00F, 8'h04, 4'h2, 4'h1};
			acq_req[i] = 1'b0;
			lut_we[i] = 1'b0;
			wr_ready[i] = 1'b0;
			trig_go[i] = 1'b0;
			pix[i] = 8'h00;
		end
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		#1;
		for (int i = 0; i < 4; i++)
		begin
			check(busy[i], 1'b0);
			check(wr_valid[i], 1'b0);
			check(cam_out[i].camera_frame_reset_out, 1'b0);
			check(cam_out[i].strobe_out, cfg[i].strobe_pol);
		end
		$display("reset test done");
		// Table XORs each value with A5, so a bypassed lookup shows at once
		for (int a = 0; a < 256; a++)
		begin
			@(posedge clk_sys);
			lut_addr <= 8'(a);
			lut_data <= 8'(a) ^ 8'hA5;
			lut_we <= '{default: 1'b1};
		end
		@(posedge clk_sys);
		lut_we <= '{default: 1'b0};
		foreach (rows[r])
			run_row(rows[r]);
		// Last row left ready low: two words held, the rest lost
		check(overrun[1], 1'b1);
		check(wr_valid[1], 1'b1);
		@(posedge clk_sys);
		cur.stall <= 2'h1;
		repeat (20) @(posedge clk_sys);
		#1 check(nw, 2);
		check(lper, 128);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 check(overrun[1], 1'b0);
		$display("overrun and second reset test done");
		final_report;
	end

	initial
	begin
		// Five rows of at most a few frames each fit well inside this span
		#600_000;
		failures++;
		$display("[ERR] t=%0t timeout got=%0h exp=%0h", $time, 0, 1);
		final_report;
	end
endmodule : test_cac_grabber
